// file: core/cmp_ctrl.sv
// Summary of operation
// [RQ1] decode D+/D- levels into 5/9/12 V modes
// [RQ2] D+ 0.6 V, D- 3.3 V enters continuous mode
// [RQ3] both lines 3.3 V keep previous mode
// [RQ4] continuous mode steps target by 200 mV
// [RQ5] continuous entry allowed from any fixed mode
// [RQ6] continuous mode exits only to 5 V
// [RQ7] enter green after debounced low current
// [RQ8] green mode disables synchronous rectifier control
// [RQ9] leave green after debounced high current
// [RQ10] debounced over-voltage latches the fault
// [RQ11] fault clears only below latch-off level
// [RQ12] over-voltage threshold follows output range
// [RQ13] debounced under-voltage reduces current limit
// [RQ14] under-voltage ends above high threshold
// [RQ15] under-voltage disables synchronous rectifier control
// [RQ16] under-voltage guard only in legacy modes
// [RQ17] latching variant turns under-voltage into fault
// [RQ18] under-voltage thresholds depend on 9/12 V
// [RQ19] debounced data-line over-voltage detected
// [RQ20] data-line over-voltage latches the fault
// [RQ21] latched fault pulls feedback output down
// [RQ22] no 2.75 V supply after acknowledge until detach
// [RQ23] debounce counters restart when condition drops
`timescale 1ns/1ps
`default_nettype none
`include "cmp_defines.svh"
module cmp_ctrl #(
    parameter int TICK_CYC = `CMP_TICK_CYC
) (
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire cmp_pkg::cmp_bus_t  bus,
    output logic [31:0]             rdata,
    input  wire cmp_pkg::cmp_dline_t dl,
    input  wire cmp_pkg::cmp_sense_t sense,
    output cmp_pkg::cmp_drive_t     drv,
    output logic                    secondary_feedback_out
);
    import cmp_pkg::*;

    // debounce limits in ticks
    localparam logic [4:0][7:0] DB_LIM = {
        8'(`CMP_TICKS(`CMP_T_DLINE_US)),
        8'(`CMP_TICKS(`CMP_T_UVP_US)),
        8'(`CMP_TICKS(`CMP_T_OVP_US)),
        8'(`CMP_TICKS(`CMP_T_GRN_DIS_US)),
        8'(`CMP_TICKS(`CMP_T_GRN_EN_US))};

    cmp_state_t st_reg;            // registered state
    cmp_state_t st_next;           // next state
    logic [4:0] db_cond;           // condition watched per channel
    logic [4:0] db_done;           // interval complete, stays high while the condition holds
    logic [4:0][7:0] cnt_next;     // next counter per channel
    logic        uvp_en;           // under-voltage guard armed
    logic        latch_set;        // any fault source fires
    cmp_status_t stat;             // status word

    // under-voltage guard only in legacy 9 V or 12 V mode
    assign uvp_en = (st_reg.mode == CMP_M_9V) || (st_reg.mode == CMP_M_12V); // RQ16

    // conditions per debounce channel
    assign db_cond[`CMP_DB_GIN]   = sense.cs_below_green & ~st_reg.green;   // RQ7
    assign db_cond[`CMP_DB_GOUT]  = ~sense.cs_below_green & st_reg.green;   // RQ9
    assign db_cond[`CMP_DB_OVP]   = sense.vin_over;                         // RQ10
    assign db_cond[`CMP_DB_UVP]   = sense.vin_under_low & uvp_en & ~st_reg.under_voltage_guard;
    // data line guard is idle while the 2.75 V supply drives the lines
    assign db_cond[`CMP_DB_DLINE] = (sense.dp_over | sense.dm_over) & ~st_reg.s275; // RQ19

    // one counter per channel, cleared whenever its condition drops
    genvar gi;
    generate
        for (gi = 0; gi < `CMP_DB_N; gi++) begin : g_db
            always_comb begin
                if (!db_cond[gi]) begin
                    cnt_next[gi] = 8'h00; // RQ23
                end else if (st_reg.tick && st_reg.cnt[gi] != DB_LIM[gi]) begin
                    cnt_next[gi] = st_reg.cnt[gi] + 8'h01;
                end else begin
                    cnt_next[gi] = st_reg.cnt[gi];
                end
            end
            assign db_done[gi] = db_cond[gi] && (st_reg.cnt[gi] == DB_LIM[gi]);
        end
    endgenerate

    // sources that enter the latched fault state
    assign latch_set = db_done[`CMP_DB_OVP] | db_done[`CMP_DB_DLINE]   // RQ10 RQ20
                     | (db_done[`CMP_DB_UVP] & st_reg.latch_var);      // RQ17

    // status word
    always_comb begin
        stat           = '0;
        stat.mode      = st_reg.mode;
        stat.latch_var = st_reg.latch_var;
        stat.ack       = st_reg.ack;
        stat.s275      = st_reg.s275;
        stat.green     = st_reg.green;
        stat.under_voltage_guard       = st_reg.under_voltage_guard;
        stat.uvp_en    = uvp_en;
        stat.fault     = st_reg.fault;
        stat.dline     = st_reg.dline_seen;
        stat.over_voltage_guard       = st_reg.ovp_seen;
    end

    // next-state logic
    always_comb begin
        st_next     = st_reg;
        st_next.cnt = cnt_next;
        // timebase divider
        st_next.tick = 1'b0;
        if (st_reg.div == 12'(TICK_CYC - 1)) begin
            st_next.div  = 12'h000;
            st_next.tick = 1'b1;
        end else begin
            st_next.div = st_reg.div + 12'h001;
        end
        // mode decode from the data lines
        if (dl.detached) begin
            // detach returns mode, target, acknowledge and 2.75 V supply to the power-on condition
            st_next.mode = CMP_M_5V;
            st_next.tgt  = `CMP_MV_5V;
            st_next.ack  = 1'b0;
            st_next.s275 = 1'b1; // RQ22
        end else begin
            if (dl.bc_start) begin
                st_next.s275 = 1'b0;
            end
            case (st_reg.mode)
                CMP_M_5V, CMP_M_9V, CMP_M_12V: begin
                    if (dl.dp == CMP_LVL_06V && dl.dm == CMP_LVL_0V) begin
                        st_next.mode = CMP_M_5V; // RQ1
                        st_next.tgt  = `CMP_MV_5V;
                        st_next.ack  = 1'b1;
                    end else if (dl.dp == CMP_LVL_33V && dl.dm == CMP_LVL_06V) begin
                        st_next.mode = CMP_M_9V; // RQ1
                        st_next.tgt  = `CMP_MV_9V;
                        st_next.ack  = 1'b1;
                    end else if (dl.dp == CMP_LVL_06V && dl.dm == CMP_LVL_06V) begin
                        st_next.mode = CMP_M_12V; // RQ1
                        st_next.tgt  = `CMP_MV_12V;
                        st_next.ack  = 1'b1;
                    end else if (dl.dp == CMP_LVL_06V && dl.dm == CMP_LVL_33V) begin
                        st_next.mode = CMP_M_CONT; // RQ2 RQ5
                        st_next.ack  = 1'b1;
                    end
                    // both lines high: reserved, hold mode  RQ3
                end
                CMP_M_CONT: begin
                    if (dl.dp == CMP_LVL_06V && dl.dm == CMP_LVL_0V) begin
                        st_next.mode = CMP_M_5V; // RQ6
                        st_next.tgt  = `CMP_MV_5V;
                    end else if (dl.inc && !dl.dec
                                 && st_reg.tgt <= `CMP_MV_12V - `CMP_MV_STEP) begin
                        st_next.tgt = st_reg.tgt + `CMP_MV_STEP; // RQ4
                    end else if (dl.dec && !dl.inc
                                 && st_reg.tgt >= `CMP_MV_MIN + `CMP_MV_STEP) begin
                        st_next.tgt = st_reg.tgt - `CMP_MV_STEP; // RQ4
                    end
                end
                default: begin
                    st_next.mode = CMP_M_5V;
                end
            endcase
            // once acknowledged, the 2.75 V supply stays off
            if (st_next.ack) begin
                st_next.s275 = 1'b0; // RQ22
            end
        end
        // green mode entry and exit
        if (db_done[`CMP_DB_GIN]) begin
            st_next.green = 1'b1; // RQ7
        end else if (db_done[`CMP_DB_GOUT]) begin
            st_next.green = 1'b0; // RQ9
        end
        // under-voltage state, leaves above the high level or when disarmed
        if (db_done[`CMP_DB_UVP] && !st_reg.latch_var) begin
            st_next.under_voltage_guard = 1'b1; // RQ13
        end else if (sense.vin_over_high || !uvp_en) begin
            st_next.under_voltage_guard = 1'b0; // RQ14 RQ16
        end
        // fault latch: a new trigger wins over the release
        if (latch_set) begin
            st_next.fault = 1'b1;
        end else if (sense.vin_latch_off) begin
            st_next.fault = 1'b0; // RQ11
        end
        // cause flags, cleared with the fault
        if (db_done[`CMP_DB_OVP]) begin
            st_next.ovp_seen = 1'b1;
        end else if (!latch_set && sense.vin_latch_off) begin
            st_next.ovp_seen = 1'b0;
        end
        if (db_done[`CMP_DB_DLINE]) begin
            st_next.dline_seen = 1'b1;
        end else if (!latch_set && sense.vin_latch_off) begin
            st_next.dline_seen = 1'b0;
        end
        // register writes
        if (bus.wr && bus.addr == `CMP_A_CTRL) begin
            st_next.latch_var = bus.wdata[0];
        end
        // register reads, answered the next cycle
        st_next.rdata = 32'h0000_0000;
        if (bus.rd) begin
            case (bus.addr)
                `CMP_A_CTRL: st_next.rdata = {31'h0000_0000, st_reg.latch_var};
                `CMP_A_STAT: st_next.rdata = stat;
                `CMP_A_TGT:  st_next.rdata = {18'h00000, st_reg.tgt};
                default:     st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_reg           <= '0;
            st_reg.mode      <= CMP_M_5V;
            st_reg.tgt       <= `CMP_MV_5V;
            st_reg.s275      <= 1'b1;
            st_reg.latch_var <= `CMP_CTRL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    always_comb begin
        drv                = '0;
        drv.tgt_mv         = st_reg.tgt;
        drv.uvp_12v_sel    = (st_reg.mode == CMP_M_12V);    // RQ18
        drv.cc_reduced     = st_reg.under_voltage_guard;                    // RQ13
        drv.sr_enable      = ~st_reg.green & ~st_reg.under_voltage_guard;  // RQ8 RQ15
        drv.supply_2v75_en = st_reg.s275;
        drv.green_mode     = st_reg.green;
        // threshold range from the active target
        if (st_reg.tgt <= `CMP_MV_5V) begin
            drv.ovp_range = CMP_OVR_6V0; // RQ12
        end else if (st_reg.tgt <= `CMP_MV_6V) begin
            drv.ovp_range = CMP_OVR_8V4;
        end else if (st_reg.tgt <= `CMP_MV_9V) begin
            drv.ovp_range = CMP_OVR_10V8;
        end else begin
            drv.ovp_range = CMP_OVR_14V4;
        end
    end
    assign secondary_feedback_out = st_reg.fault; // RQ21
    assign rdata = st_reg.rdata;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    fault_hold_a: assert property (st_reg.fault && !sense.vin_latch_off |=> st_reg.fault) // RQ11
        else $error("fault released above latch-off");
    fb_pull_a: assert property (st_reg.fault |-> secondary_feedback_out) // RQ21
        else $error("feedback not pulled during fault");
    ovp_latch_a: assert property (db_done[`CMP_DB_OVP] |=> st_reg.fault && st_reg.ovp_seen) // RQ10
        else $error("over-voltage did not latch");
    dline_latch_a: assert property (db_done[`CMP_DB_DLINE] |=> st_reg.fault) // RQ20
        else $error("data line fault did not latch");
    dline_time_a: assert property ($rose(st_reg.dline_seen)
        |-> $past(st_reg.cnt[`CMP_DB_DLINE]) == DB_LIM[`CMP_DB_DLINE]) // RQ19
        else $error("data line flag set before interval");
    uvp_cc_a: assert property (db_done[`CMP_DB_UVP] && !st_reg.latch_var
        |=> st_reg.under_voltage_guard && drv.cc_reduced) // RQ13
        else $error("under-voltage did not reduce current");
    uvp_latch_a: assert property (db_done[`CMP_DB_UVP] && st_reg.latch_var
        |=> st_reg.fault && !st_reg.under_voltage_guard) // RQ17
        else $error("latching variant did not latch");
    uvp_exit_a: assert property (st_reg.under_voltage_guard && sense.vin_over_high |=> !st_reg.under_voltage_guard) // RQ14
        else $error("under-voltage not left");
    sr_off_a: assert property (st_reg.green || st_reg.under_voltage_guard |-> !drv.sr_enable) // RQ8 RQ15
        else $error("rectifier enabled while disabled");
    cont_nouvp_a: assert property (st_reg.mode == CMP_M_CONT |=> !st_reg.under_voltage_guard) // RQ16
        else $error("under-voltage in continuous mode");
    reserved_a: assert property (dl.dp == CMP_LVL_33V && dl.dm == CMP_LVL_33V
        && !dl.detached |=> $stable(st_reg.mode)) // RQ3
        else $error("reserved code changed mode");
    step_inc_a: assert property (st_reg.mode == CMP_M_CONT && dl.inc && !dl.dec
        && !dl.detached && st_reg.tgt <= `CMP_MV_12V - `CMP_MV_STEP
        && !(dl.dp == CMP_LVL_06V && dl.dm == CMP_LVL_0V)
        |=> st_reg.tgt == $past(st_reg.tgt) + `CMP_MV_STEP) // RQ4
        else $error("increment not 200 mV");
    db_restart_a: assert property (!db_cond[`CMP_DB_GIN] |=> st_reg.cnt[`CMP_DB_GIN] == 8'h00) // RQ23
        else $error("debounce did not restart");
    no275_a: assert property (st_reg.ack && !dl.detached |=> !st_reg.s275) // RQ22
        else $error("2.75 V supply after acknowledge");
    green_cv: cover property (db_done[`CMP_DB_GIN] ##1 st_reg.green);
    fault_cv: cover property (st_reg.fault ##[1:50] !st_reg.fault);
    step_cv:  cover property (st_reg.mode == CMP_M_CONT && dl.inc ##1 $changed(st_reg.tgt));
    uvp_cv:   cover property ($rose(st_reg.under_voltage_guard));
endmodule // cmp_ctrl
`default_nettype wire

// file: core/cmp_defines.svh
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH
// timebase
`define CMP_CLK_MHZ      25
`define CMP_TICK_US      100
`define CMP_TICK_CYC     (`CMP_CLK_MHZ * `CMP_TICK_US)
`define CMP_TICKS(us)    (((us) + `CMP_TICK_US - 1) / `CMP_TICK_US)
// debounce intervals in microseconds
`define CMP_T_GRN_EN_US  2000
`define CMP_T_GRN_DIS_US 500
`define CMP_T_OVP_US     200
`define CMP_T_UVP_US     1000
`define CMP_T_DLINE_US   3000
// debounce channel indices
`define CMP_DB_GIN       0
`define CMP_DB_GOUT      1
`define CMP_DB_OVP       2
`define CMP_DB_UVP       3
`define CMP_DB_DLINE     4
`define CMP_DB_N         5
// voltage targets in millivolts
`define CMP_MV_5V        14'h1388
`define CMP_MV_6V        14'h1770
`define CMP_MV_9V        14'h2328
`define CMP_MV_12V       14'h2EE0
`define CMP_MV_MIN       14'h0E10
`define CMP_MV_STEP      14'h00C8
// register offsets and reset values
`define CMP_A_CTRL       4'h0
`define CMP_A_STAT       4'h4
`define CMP_A_TGT        4'h8
`define CMP_CTRL_RST     1'h0
`endif

// file: core/cmp_pkg.sv
package cmp_pkg;
    // coded level seen on one data line
    typedef enum logic [1:0] {
        CMP_LVL_0V  = 2'h0,
        CMP_LVL_06V = 2'h1,
        CMP_LVL_33V = 2'h2
    } cmp_lvl_t;
    // output mode, one-hot
    typedef enum logic [3:0] {
        CMP_M_5V   = 4'h1,
        CMP_M_9V   = 4'h2,
        CMP_M_12V  = 4'h4,
        CMP_M_CONT = 4'h8
    } cmp_mode_t;
    // over-voltage threshold range
    typedef enum logic [1:0] {
        CMP_OVR_6V0  = 2'h0,
        CMP_OVR_8V4  = 2'h1,
        CMP_OVR_10V8 = 2'h2,
        CMP_OVR_14V4 = 2'h3
    } cmp_ovr_t;
    // register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cmp_bus_t;
    // data line side: decoded levels and protocol events
    typedef struct packed {
        cmp_lvl_t dp;
        cmp_lvl_t dm;
        logic     inc;
        logic     dec;
        logic     detached;
        logic     bc_start;
    } cmp_dline_t;
    // analog comparator outputs
    typedef struct packed {
        logic cs_below_green;
        logic vin_over;
        logic vin_under_low;
        logic vin_over_high;
        logic vin_latch_off;
        logic dp_over;
        logic dm_over;
    } cmp_sense_t;
    // drives toward the analog side
    typedef struct packed {
        logic [13:0] tgt_mv;
        cmp_ovr_t    ovp_range;
        logic        uvp_12v_sel;
        logic        cc_reduced;
        logic        sr_enable;
        logic        supply_2v75_en;
        logic        green_mode;
    } cmp_drive_t;
    // status register layout
    typedef struct packed {
        logic [18:0] zero;
        cmp_mode_t   mode;
        logic        latch_var;
        logic        ack;
        logic        s275;
        logic        green;
        logic        under_voltage_guard;
        logic        uvp_en;
        logic        fault;
        logic        dline;
        logic        over_voltage_guard;
    } cmp_status_t;
    // complete state of the controller
    typedef struct packed {
        cmp_mode_t        mode;
        logic [13:0]      tgt;
        logic             ack;
        logic             s275;
        logic             green;
        logic             under_voltage_guard;
        logic             fault;
        logic             ovp_seen;
        logic             dline_seen;
        logic             latch_var;
        logic [11:0]      div;
        logic             tick;
        logic [4:0][7:0]  cnt;
        logic [31:0]      rdata;
    } cmp_state_t;
endpackage

// file: testbench/cmp_portable_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_portable_model (
    input  wire logic               clock,
    input  wire logic               rstn,
    output var cmp_pkg::cmp_dline_t dl
);
    import cmp_pkg::*;
    // code outside the table: lines released, nothing requested
    localparam cmp_lvl_t LVL_NONE = cmp_lvl_t'(2'h3);

    // attached, lines released, no step request
    initial begin
        dl = '{LVL_NONE, LVL_NONE, 1'b0, 1'b0, 1'b0, 1'b0};
    end

    // drive a level pair and hold it; 0.6/3.3 asks for stepping
    task automatic send_code(input cmp_lvl_t p, input cmp_lvl_t m);
        wait (rstn === 1'b1);
        @(posedge clock);
        dl.dp <= p;
        dl.dm <= m;
        repeat (2) @(posedge clock);
    endtask

    // back-to-back step pulses, one per cycle held
    task automatic step(input logic up, input int n);
        @(posedge clock);
        dl.inc <= up;
        dl.dec <= ~up;
        repeat (n) @(posedge clock);
        dl.inc <= 1'b0;
        dl.dec <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // unplug: release both lines and flag the detach
    task automatic unplug();
        @(posedge clock);
        dl.detached <= 1'b1;
        dl.dp       <= LVL_NONE;
        dl.dm       <= LVL_NONE;
        repeat (2) @(posedge clock);
        dl.detached <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // start of the port-detection handshake
    task automatic start_bc();
        @(posedge clock);
        dl.bc_start <= 1'b1;
        @(posedge clock);
        dl.bc_start <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
endmodule // cmp_portable_model
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmp_defines.svh"
module tb;
    import cmp_pkg::*;
    localparam int          TB_TICK = 4;             // shortened timebase
    localparam logic [31:0] ALL     = 32'hFFFF_FFFF; // whole word
    localparam logic [31:0] M_MODE  = 32'h0000_1FC8; // mode, latch_var, ack, s275, uvp_en
    // fixed-mode table: line codes, mode, target, threshold range
    localparam cmp_lvl_t    DP_TAB [3] = '{CMP_LVL_06V, CMP_LVL_33V, CMP_LVL_06V};
    localparam cmp_lvl_t    DM_TAB [3] = '{CMP_LVL_0V, CMP_LVL_06V, CMP_LVL_06V};
    localparam cmp_mode_t   MD_TAB [3] = '{CMP_M_5V, CMP_M_9V, CMP_M_12V};
    localparam logic [13:0] MV_TAB [3] = '{`CMP_MV_5V, `CMP_MV_9V, `CMP_MV_12V};
    localparam cmp_ovr_t    OV_TAB [3] = '{CMP_OVR_6V0, CMP_OVR_10V8, CMP_OVR_14V4};
    localparam logic        UE_TAB [3] = '{1'b0, 1'b1, 1'b1};
    logic        clock;                  // 25 MHz
    logic        rstn;                   // async reset, low active
    cmp_bus_t    bus;                    // register requests
    logic [31:0] rdata;                  // read data
    cmp_dline_t  dl;                     // from the portable model
    cmp_sense_t  sense;                  // comparator levels
    cmp_drive_t  drv;                    // toward the analog side
    logic        secondary_feedback_out; // fault pull-down
    logic [31:0] rd_val;                 // last read word
    int          num_errors;             // mismatches
    int          n_checks;               // comparisons

    cmp_ctrl #(.TICK_CYC(TB_TICK)) u_cmp_ctrl (.clock(clock), .rstn(rstn), .bus(bus),
        .rdata(rdata), .dl(dl), .sense(sense), .drv(drv),
        .secondary_feedback_out(secondary_feedback_out));
    cmp_portable_model u_cmp_portable_model (.clock(clock), .rstn(rstn), .dl(dl));

    // clock source
    initial clock = 1'b0;
    always #20 clock = ~clock;

    // compare one result word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clock);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        rd_val = rdata;
        chk(rd_val & m, e);
    endtask
    // wait whole debounce ticks, then let outputs settle
    task automatic ticks(input int n);
        repeat (n * TB_TICK) @(posedge clock);
        #1;
    endtask
    // pulse the latch-off comparator
    task automatic latch_off();
        @(posedge clock);
        sense.vin_latch_off <= 1'b1;
        repeat (2) @(posedge clock);
        sense.vin_latch_off <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    // counts, verdict, end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: the tests need well under 8000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        print_verdict();
    end

    // test sequence
    initial begin
        num_errors = 0;
        n_checks   = 0;
        rstn       = 1'b0;
        bus        = '0;
        sense      = '0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        // reset state, read-only and unmapped places
        rd_chk(`CMP_A_STAT, ALL, 32'h0000_0240);
        rd_chk(`CMP_A_CTRL, ALL, 32'h0);
        wr_reg(`CMP_A_TGT, 32'h0);
        wr_reg(4'hC, ALL);
        rd_chk(`CMP_A_TGT, ALL, {18'h0, `CMP_MV_5V});
        rd_chk(4'hC, ALL, 32'h0);
        chk(drv.sr_enable, 1'b1);
        chk(secondary_feedback_out, 1'b0);
        $display("test reset done");
        // every fixed mode, reserved code, continuous entry and exit
        for (int i = 0; i < 3; i++) begin
            u_cmp_portable_model.send_code(DP_TAB[i], DM_TAB[i]);
            rd_chk(`CMP_A_STAT, M_MODE, {19'h0, MD_TAB[i], 5'h08, UE_TAB[i], 3'h0});
            chk(drv.tgt_mv, MV_TAB[i]);
            chk(drv.ovp_range, OV_TAB[i]);
            u_cmp_portable_model.send_code(CMP_LVL_33V, CMP_LVL_33V);
            rd_chk(`CMP_A_STAT, M_MODE, {19'h0, MD_TAB[i], 5'h08, UE_TAB[i], 3'h0});
            u_cmp_portable_model.send_code(CMP_LVL_06V, CMP_LVL_33V);
            rd_chk(`CMP_A_STAT, M_MODE, {19'h0, CMP_M_CONT, 9'h080});
            chk(drv.tgt_mv, MV_TAB[i]);
            u_cmp_portable_model.send_code(CMP_LVL_06V, CMP_LVL_0V);
            rd_chk(`CMP_A_STAT, M_MODE, {19'h0, CMP_M_5V, 9'h080});
        end
        chk(drv.uvp_12v_sel, 1'b0);
        $display("test modes done");
        // stepping: ignored outside, clamped at the floor, ranges follow
        u_cmp_portable_model.step(1'b1, 1);
        chk(drv.tgt_mv, `CMP_MV_5V);
        u_cmp_portable_model.send_code(CMP_LVL_06V, CMP_LVL_33V);
        u_cmp_portable_model.step(1'b0, 9);
        chk(drv.tgt_mv, `CMP_MV_MIN);
        u_cmp_portable_model.step(1'b1, 12);
        chk(drv.tgt_mv, `CMP_MV_6V);
        chk(drv.ovp_range, CMP_OVR_8V4);
        u_cmp_portable_model.step(1'b1, 1);
        chk(drv.ovp_range, CMP_OVR_10V8);
        u_cmp_portable_model.send_code(CMP_LVL_33V, CMP_LVL_06V);
        rd_chk(`CMP_A_STAT, M_MODE, {19'h0, CMP_M_CONT, 9'h080});
        // under-voltage guard stays off while stepping
        @(posedge clock);
        sense.vin_under_low <= 1'b1;
        ticks(12);
        chk(drv.cc_reduced, 1'b0);
        $display("test stepping done");
        // under-voltage in 9 V, then 12 V thresholds; continuous leaves only to 5 V
        u_cmp_portable_model.send_code(CMP_LVL_06V, CMP_LVL_0V);
        u_cmp_portable_model.send_code(CMP_LVL_33V, CMP_LVL_06V);
        ticks(12);
        chk({drv.cc_reduced, drv.sr_enable}, 2'b10);
        chk(secondary_feedback_out, 1'b0);
        @(posedge clock);
        sense.vin_under_low <= 1'b0;
        sense.vin_over_high <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk(drv.cc_reduced, 1'b0);
        sense.vin_over_high <= 1'b0;
        u_cmp_portable_model.send_code(CMP_LVL_06V, CMP_LVL_06V);
        chk(drv.uvp_12v_sel, 1'b1);
        // latching variant: under-voltage turns into the fault
        wr_reg(`CMP_A_CTRL, 32'h1);
        rd_chk(`CMP_A_CTRL, ALL, 32'h1);
        @(posedge clock);
        sense.vin_under_low <= 1'b1;
        ticks(12);
        chk(secondary_feedback_out, 1'b1);
        sense.vin_under_low <= 1'b0;
        latch_off();
        chk(secondary_feedback_out, 1'b0);
        wr_reg(`CMP_A_CTRL, 32'h0);
        $display("test under-voltage done");
        // over-voltage: not early, latched, held until latch-off
        @(posedge clock);
        sense.vin_over <= 1'b1;
        repeat (TB_TICK) @(posedge clock);
        #1;
        chk(secondary_feedback_out, 1'b0);
        ticks(2);
        rd_chk(`CMP_A_STAT, 32'h5, 32'h5);
        @(posedge clock);
        sense.vin_over <= 1'b0;
        ticks(3);
        chk(secondary_feedback_out, 1'b1);
        latch_off();
        chk(secondary_feedback_out, 1'b0);
        $display("test over-voltage done");
        // green: interrupted low current restarts the count
        @(posedge clock);
        sense.cs_below_green <= 1'b1;
        ticks(10);
        sense.cs_below_green <= 1'b0;
        repeat (2) @(posedge clock);
        sense.cs_below_green <= 1'b1;
        ticks(15);
        chk(drv.green_mode, 1'b0);
        ticks(8);
        chk({drv.green_mode, drv.sr_enable}, 2'b10);
        sense.cs_below_green <= 1'b0;
        ticks(7);
        chk({drv.green_mode, drv.sr_enable}, 2'b01);
        $display("test green done");
        // data lines: guard off in 2.75 V supply, then both lines trip
        u_cmp_portable_model.unplug();
        rd_chk(`CMP_A_STAT, M_MODE, {19'h0, CMP_M_5V, 9'h040});
        chk(drv.supply_2v75_en, 1'b1);
        sense.dp_over <= 1'b1;
        ticks(32);
        chk(secondary_feedback_out, 1'b0);
        u_cmp_portable_model.start_bc();
        rd_chk(`CMP_A_STAT, 32'h40, 32'h0);
        chk(drv.supply_2v75_en, 1'b0);
        for (int j = 0; j < 2; j++) begin
            sense.dp_over <= (j == 0);
            sense.dm_over <= (j == 1);
            ticks(32);
            rd_chk(`CMP_A_STAT, 32'h6, 32'h6);
            chk(secondary_feedback_out, 1'b1);
            sense.dp_over <= 1'b0;
            sense.dm_over <= 1'b0;
            latch_off();
            chk(secondary_feedback_out, 1'b0);
        end
        $display("test data line done");
        print_verdict();
    end
endmodule // tb
`default_nettype wire
